// ==== wdg_defines.vh ====
// Constants for the dual watchdog: counter layouts, keys, reset values.
// Assumes inclusion by bare name from the watchdog design files.
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH

// ***************************************************************
// Clocking
// ***************************************************************
`define WDG_MCLK_HZ        10000000
`define WDG_LSI_HZ         128000
// Window counter steps once per this many mclk cycles
`define WDG_WIN_PRESC      16'h0400
// Strap is taken once this many settling edges have passed
`define WDG_STRAP_WAIT     2'h3

// ***************************************************************
// Window watchdog counter
// ***************************************************************
`define WDG_WIN_W          7
`define WDG_WIN_MSB        6
`define WDG_WIN_RST_CNT    7'h7F
`define WDG_WIN_RST_WIN    7'h7F
// Terminal count: a tick at this value resets the device, and the count holds here
`define WDG_WIN_TERM       7'h40

// ***************************************************************
// Independent watchdog counter and keys
// ***************************************************************
`define WDG_IND_W          12
`define WDG_IND_RELOAD     12'h0FFF
`define WDG_KEY_START      8'hCC
`define WDG_KEY_REFRESH    8'hAA

`endif

// ==== wdg_sync_edge.v ====
// Two-stage synchroniser with rising-edge pulse for an async input.
// Assumes a single mclk domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module wdg_sync_edge (
   input  wire mclk,
   input  wire resetn,
   input  wire async_in,
   output wire sync_out,
   output wire rise_pulse
);

   reg meta_r;
   reg sync_r;
   reg prev_r;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign sync_out   = sync_r;
   assign rise_pulse = sync_r & ~prev_r;

endmodule // wdg_sync_edge

`default_nettype wire

// ==== wdg_top.v ====
// Dual watchdog: a window watchdog on mclk and an independent watchdog
// stepped by rising edges of the low-speed internal oscillator.
// Assumes software strobes come from mclk logic; the oscillator and the
// option strap are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.vh"

module wdg_top #(
   parameter [15:0] WIN_PRESC = `WDG_WIN_PRESC
) (
   input  wire                       mclk,
   input  wire                       resetn,
   input  wire                       low_speed_internal_osc,
   input  wire                       opt_hw_ind_en,
   input  wire                       win_activate,
   input  wire                       win_disable,
   input  wire                       win_refresh,
   input  wire [`WDG_WIN_W-1:0]      win_refresh_val,
   input  wire [`WDG_WIN_W-1:0]      win_window_val,
   input  wire                       win_window_wr,
   input  wire                       ind_key_wr,
   input  wire [7:0]                 ind_key,
   input  wire                       ind_disable,
   output reg                        win_active,
   output reg                        ind_active,
   output reg  [`WDG_WIN_W-1:0]      win_count,
   output reg  [`WDG_IND_W-1:0]      ind_count,
   output reg                        win_reset_cause,
   output reg                        ind_reset_cause,
   output reg                        wdg_reset_req
);

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function [`WDG_WIN_W-1:0] win_load;
      input [`WDG_WIN_W-1:0] val;
      begin
         // Loading below the terminal bit would reset at once
         win_load = val | `WDG_WIN_TERM;
      end
   endfunction

   // ***************************************************************
   // Asynchronous inputs
   // ***************************************************************
   wire osc_rise;
   wire opt_sync;

   wdg_sync_edge u_osc_sync (
      .mclk       (mclk),
      .resetn     (resetn),
      .async_in   (low_speed_internal_osc),
      .sync_out   (),
      .rise_pulse (osc_rise)
   );

   wdg_sync_edge u_opt_sync (
      .mclk       (mclk),
      .resetn     (resetn),
      .async_in   (opt_hw_ind_en),
      .sync_out   (opt_sync),
      .rise_pulse ()
   );

   // Strap settles through the synchroniser before being sampled once
   reg [1:0] strap_wait_r;
   reg       strap_done_r;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         strap_wait_r <= 2'h0;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_wait_r <= strap_wait_r + 2'h1;
         if (strap_wait_r == `WDG_STRAP_WAIT)
            strap_done_r <= 1'b1;
      end
   end

   wire strap_sample = ~strap_done_r & (strap_wait_r == `WDG_STRAP_WAIT);

   // ***************************************************************
   // Window prescaler
   // ***************************************************************
   reg  [15:0] presc_r;
   wire        win_tick = (presc_r == 16'h0000);

   always @(posedge mclk or negedge resetn) begin
      if (!resetn)
         presc_r <= 16'h0000;
      else if (win_tick)
         presc_r <= WIN_PRESC - 16'h0001;
      else
         presc_r <= presc_r - 16'h0001;
   end

   // ***************************************************************
   // Window watchdog
   // ***************************************************************
   reg [`WDG_WIN_W-1:0] window_r;
   reg [`WDG_WIN_W-1:0] window_nxt;
   reg [`WDG_WIN_W-1:0] win_count_nxt;
   reg                  win_active_nxt;
   reg                  win_fire_nxt;

   // Disable strobes are deliberately unused: nothing clears active
   wire unused_dis = win_disable | ind_disable;

   always @* begin
      win_fire_nxt = 1'b0;
      if (win_active) begin
         if (win_refresh && win_count > window_r)
            win_fire_nxt = 1'b1;
         else if (!win_refresh && win_tick && win_count == `WDG_WIN_TERM)
            win_fire_nxt = 1'b1;
      end
   end

   // An in-window refresh beats a tick in the same cycle; the counter parks at the
   // terminal count, and each later tick there fires again into the held request
   always @* begin
      window_nxt     = window_r;
      win_active_nxt = win_active;
      win_count_nxt  = win_count;
      if (win_window_wr)
         window_nxt = win_window_val;
      if (win_activate && !win_active) begin
         win_active_nxt = 1'b1;
         win_count_nxt  = win_load(win_refresh_val);
      end else if (win_active) begin
         if (win_refresh && win_count <= window_r)
            win_count_nxt = win_load(win_refresh_val);
         else if (win_tick && win_count != `WDG_WIN_TERM)
            win_count_nxt = win_count - 7'h01;
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         window_r   <= `WDG_WIN_RST_WIN;
         win_active <= 1'b0;
         win_count  <= `WDG_WIN_RST_CNT;
      end else begin
         // Active has no clearing path short of reset
         window_r   <= window_nxt;
         win_active <= win_active_nxt;
         win_count  <= win_count_nxt;
      end
   end

   // ***************************************************************
   // Independent watchdog
   // ***************************************************************
   reg ind_fire_nxt;

   wire key_start   = ind_key_wr && (ind_key == `WDG_KEY_START);
   wire key_refresh = ind_key_wr && (ind_key == `WDG_KEY_REFRESH);

   always @* begin
      ind_fire_nxt = ind_active && !key_refresh && osc_rise &&
                     (ind_count == {`WDG_IND_W{1'b0}});
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ind_active <= 1'b0;
         ind_count  <= `WDG_IND_RELOAD;
      end else begin
         if (!ind_active) begin
            if (key_start || (strap_sample && opt_sync)) begin
               ind_active <= 1'b1;
               ind_count  <= `WDG_IND_RELOAD;
            end
         end else if (key_refresh) begin
            ind_count <= `WDG_IND_RELOAD;
         end else if (osc_rise && ind_count != {`WDG_IND_W{1'b0}}) begin
            // Mclk edges alone never advance this counter
            ind_count <= ind_count - 12'h001;
         end
      end
   end

   // ***************************************************************
   // Reset request
   // ***************************************************************
   // Request is held until the device reset arrives; either source
   // alone is enough, and both causes are recorded
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         win_reset_cause <= 1'b0;
         ind_reset_cause <= 1'b0;
         wdg_reset_req   <= 1'b0;
      end else begin
         if (win_fire_nxt)
            win_reset_cause <= 1'b1;
         if (ind_fire_nxt)
            ind_reset_cause <= 1'b1;
         if (win_fire_nxt || ind_fire_nxt || unused_dis & 1'b0)
            wdg_reset_req <= 1'b1;
      end
   end

endmodule // wdg_top

`default_nettype wire

// ==== wdg_top_properties.sv ====
// Port-level checks of the dual watchdog.
// Bound into wdg_top; one mclk domain, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module wdg_props (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        win_activate,
   input wire logic        win_refresh,
   input wire logic        ind_key_wr,
   input wire logic        win_active,
   input wire logic        ind_active,
   input wire logic [6:0]  win_count,
   input wire logic [11:0] ind_count,
   input wire logic        win_reset_cause,
   input wire logic        ind_reset_cause,
   input wire logic        wdg_reset_req
);
   // ******
   // Checks
   // ******
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   sequence win_loaded;
      $past(win_activate) && win_count[6];
   endsequence
   chk_win_hold: assert property (win_active |=> win_active)
      else $error("window stopped");
   chk_win_start: assert property ($rose(win_active) |-> win_loaded)
      else $error("window start");
   chk_ind_start: assert property ($rose(ind_active) |->
      ind_count == 12'hFFF) else $error("ind start");
   chk_win_cause: assert property ($rose(win_reset_cause) |->
      $past(win_refresh) || $past(win_count) == 7'h40)
      else $error("window cause");
   chk_req_hold: assert property (wdg_reset_req |=> wdg_reset_req)
      else $error("request dropped");
   // Counts after a request are left open, so steps are checked before it
   chk_win_step: assert property (win_active && $past(win_active) &&
      !$past(win_refresh) && !wdg_reset_req && $changed(win_count)
      |-> win_count == $past(win_count) - 7'h01) else $error("win step");
   chk_ind_step: assert property (ind_active && $past(ind_active) &&
      !$past(ind_key_wr) && !wdg_reset_req && $changed(ind_count)
      |-> ind_count == $past(ind_count) - 12'h001) else $error("ind step");
   chk_ind_cause: assert property ($rose(ind_reset_cause) |->
      $past(ind_count) == 12'h000) else $error("ind cause");
endmodule // wdg_props
bind wdg_top wdg_props u_props (.*);
`default_nettype wire

// ==== wdg_top_tb.sv ====
// Directed bench for the dual watchdog.
// Short window prescaler; oscillator stand-in runs at mclk/8.
`timescale 1ns/1ps
`default_nettype none
module wdg_top_tb;
   logic             mclk, resetn, osc, strap, run;
   logic             act, rf, dis, ww, kw, idis;
   logic [6:0]       val, win;
   logic [7:0]       key;
   wire logic        w_on, i_on, w_rc, i_rc, req;
   wire logic [6:0]  w_cnt;
   wire logic [11:0] i_cnt;
   int               err_count, num_checks, cyc, oc;
   wdg_top #(.WIN_PRESC(16'h0004)) dut (.mclk(mclk), .resetn(resetn),
      .low_speed_internal_osc(osc), .opt_hw_ind_en(strap),
      .win_activate(act), .win_disable(dis), .win_refresh(rf),
      .win_refresh_val(val), .win_window_val(win), .win_window_wr(ww),
      .ind_key_wr(kw), .ind_key(key), .ind_disable(idis),
      .win_active(w_on), .ind_active(i_on), .win_count(w_cnt),
      .ind_count(i_cnt), .win_reset_cause(w_rc),
      .ind_reset_cause(i_rc), .wdg_reset_req(req));
   initial forever #50 mclk = ~mclk;
   // Fast oscillator keeps the 4096-step countdown inside the run
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      oc <= oc + run;
      osc <= oc[2];
      if (cyc == 60000) begin
         err_count++;
         conclude();
      end
   end
   task conclude;
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [13:0] got, input logic [13:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rst(input logic s);
      // Mid-run resets start on an edge like every other input
      if (resetn)
         @(posedge mclk);
      resetn <= 1'b0;
      strap <= s;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
   endtask
   task go(input logic [5:0] v);
      @(posedge mclk);
      {act, rf, dis, ww, kw, idis} <= v;
      @(posedge mclk);
      {act, rf, dis, ww, kw, idis} <= 6'h00;
      #1;
   endtask
   task wt(input int n, input logic [6:0] lim);
      // Outputs are looked at past the edge that updates them
      for (int i = 0; i < n && req !== 1'b1 && w_cnt > lim; i++) begin
         @(posedge mclk);
         #1;
      end
   endtask
   // *********
   // Scenarios
   // *********
   task t_early;
      rst(1'b0);
      chk({req, w_on, i_on, w_cnt}, 10'h07F);
      chk(i_cnt, 12'hFFF);
      @(posedge mclk);
      val <= 7'h25;
      win <= 7'h50;
      go(6'h24);
      chk({w_on, w_cnt[6:1]}, 7'h72);
      go(6'h08);
      @(posedge mclk);
      key <= 8'hAA;
      go(6'h12);
      chk({w_on, i_on, req, w_rc, i_rc}, 5'h16);
      @(posedge mclk);
      key <= 8'hCC;
      go(6'h02);
      chk(i_on, 1'b1);
   endtask
   task t_late;
      rst(1'b0);
      @(posedge mclk);
      val <= 7'h7F;
      go(6'h24);
      wt(400, 7'h4F);
      go(6'h10);
      chk({req, w_cnt[6:1]}, 7'h3F);
      wt(400, 7'h00);
      chk({w_rc, i_rc, req}, 3'h5);
   endtask
   task t_ind;
      rst(1'b1);
      chk({i_on, w_on, i_cnt}, 14'h2FFF);
      run <= 1'b1;
      repeat (40) @(posedge mclk);
      #1;
      chk(i_cnt < 12'hFFF, 1'b1);
      @(posedge mclk);
      key <= 8'hAA;
      go(6'h03);
      chk({i_on, i_cnt[11:1]}, 12'hFFF);
      wt(40000, 7'h00);
      chk({i_rc, w_rc, req}, 3'h5);
   endtask
   initial begin
      {mclk, resetn, osc, strap, run} = 5'h00;
      {act, rf, dis, ww, kw, idis} = 6'h00;
      {val, win, key} = 22'h00_0000;
      t_early();
      t_late();
      t_ind();
      conclude();
   end
endmodule // wdg_top_tb
`default_nettype wire
